// ===== logic/irsc_consts.svh
// Constants for the interrupt, reset and standby RAM control block
`ifndef IRSC_CONSTS_SVH
`define IRSC_CONSTS_SVH

// =====================================================
// Register map
`define IRSC_RAMCTL_OFS    8'h14
`define IRSC_STBY_BIT      7
`define IRSC_RAMEN_BIT     6

// =====================================================
// Vector addresses, high byte of each pair
`define IRSC_VEC_RESET     16'hfffe
`define IRSC_VEC_NMI       16'hfffc
`define IRSC_VEC_TRAP      16'hfffa
`define IRSC_VEC_EXT       16'hfff8
`define IRSC_VEC_CAPTURE   16'hfff6
`define IRSC_VEC_COMPARE   16'hfff4
`define IRSC_VEC_OVERFLOW  16'hfff2
`define IRSC_VEC_SERIAL    16'hfff0

// =====================================================
// Memory map and sequencing
`define IRSC_RAM_FIRST     16'h0080
`define IRSC_RAM_LAST      16'h00ff
`define IRSC_STBY_LAST     16'h00bf
`define IRSC_NO_RAM_MODE   3'h3
`define IRSC_STACK_LAST    3'h4
`define IRSC_DIV_LAST      2'h3

`endif

// ===== logic/irsc_pkg.sv
// Types for the interrupt, reset and standby RAM control block
package irsc_pkg;

	typedef enum logic [1:0] {
		IRSC_IDLE   = 2'h0,
		IRSC_STACK  = 2'h1,
		IRSC_VECTOR = 2'h3,
		IRSC_RESET  = 2'h2
	} irsc_state_t;

	typedef enum logic [2:0] {
		IRSC_SRC_NMI      = 3'h0,
		IRSC_SRC_TRAP     = 3'h1,
		IRSC_SRC_EXT      = 3'h2,
		IRSC_SRC_CAPTURE  = 3'h3,
		IRSC_SRC_COMPARE  = 3'h4,
		IRSC_SRC_OVERFLOW = 3'h5,
		IRSC_SRC_SERIAL   = 3'h6,
		IRSC_SRC_RESET    = 3'h7
	} irsc_src_t;

	// Stack order: PC, index, acc A, acc B, condition codes
	typedef enum logic [2:0] {
		IRSC_PUSH_PC = 3'h0,
		IRSC_PUSH_X  = 3'h1,
		IRSC_PUSH_A  = 3'h2,
		IRSC_PUSH_B  = 3'h3,
		IRSC_PUSH_CC = 3'h4
	} irsc_push_t;

endpackage : irsc_pkg

// ===== logic/irsc_ctrl.sv
// Interrupt priority, reset entry, bus clock and RAM control register
//
// The APB register port was chosen for this implementation.
`include "irsc_consts.svh"
// How it works
// R1: Non-maskable request always taken at boundary
// R2: Maskable needs mask clear and source enable
// R3: Timer/serial on internal line, others external
// R4: External line beats internal line
// R5: Internal sources in fixed priority order
// R6: Push PC, index, A, B, codes
// R7: Set mask, load vector, resume
// R8: Reset, NMI, trap, external vector pairs
// R9: Capture, compare, overflow, serial vector pairs
// R10: NMI falling edge, held one E-cycle
// R11: NMI finishes instruction then vectors FFFC
// R12: Reset held low three E-cycles
// R13: Mode pins latched on reset release
// R14: Address high forced, mask set in reset
// R15: Eight modes steer pins, map, vectors
// R16: RAM enable set if standby power present
// R17: RAM internal only when enabled, not mode 3
// R18: Standby bit cleared by low supply, software sets
// R19: Standby RAM and bits kept in powerdown
// R20: Software clears enable, sets standby bit
// R21: Bus clock is clock divided by four
// R22: External line is level sensitive
// R23: Bits 0 to 5 read zero, ignore writes
module irsc_ctrl #(
	parameter logic [7:0] EXT_VEC_MODES = 8'h00 // Modes with external vectors
) (
	input  wire logic        pclk,           // Clock
	input  wire logic        presetn,        // Async reset, active low
	input  wire logic        clk_en,         // Freezes all state when low
	input  wire logic        psel,           // APB select
	input  wire logic        penable,        // APB enable
	input  wire logic        pwrite,         // APB write
	input  wire logic [7:0]  paddr,          // APB byte address
	input  wire logic [31:0] pwdata,         // APB write data
	output logic      [31:0] prdata,         // APB read data
	output logic             pready,         // APB ready
	output logic             pslverr,        // APB error, unmapped
	input  wire logic        nmi_n,          // Non-maskable pin
	input  wire logic        ext_line_n,     // External maskable pin
	input  wire logic        port3_input_strobe, // Strobe request
	input  wire logic        chip_clear_n,   // Chip clear pin
	input  wire logic [2:0]  mode_pins,      // Port 2 bits 2..0
	input  wire logic        standby_power_ok, // Standby supply good
	input  wire logic        capture_flag,   // Timer capture
	input  wire logic        compare_flag,   // Timer compare
	input  wire logic        overflow_flag,  // Timer overflow
	input  wire logic [2:0]  timer_irq_en,   // Capture, compare, overflow
	input  wire logic        rx_full_flag,   // Serial receive full
	input  wire logic        overrun_framing_flag, // Serial error
	input  wire logic        tx_empty_flag,  // Serial transmit empty
	input  wire logic        serial_irq_en,  // Serial enable
	input  wire logic        instr_done,     // CPU at boundary
	input  wire logic        soft_trap,      // Trap instruction
	input  wire logic        mask_set,       // CPU sets mask
	input  wire logic        mask_clear,     // CPU clears mask
	input  wire logic        stack_ack,      // One push done
	input  wire logic        vec_ack,        // Vector loaded
	input  wire logic [15:0] cpu_addr,       // CPU address
	output logic             bus_clk_e,      // Bus clock E
	output logic             stack_req,      // Push request
	output logic      [2:0]  stack_item,     // Item to push
	output logic             vec_req,        // Vector fetch request
	output logic      [15:0] vec_addr,       // Vector pair high byte
	output logic             vec_external,   // Vector fetched outside
	output logic             mask_flag,      // Interrupt mask
	output logic      [2:0]  mode_sel,       // Latched mode
	output logic             addr_high_force, // Address lines high
	output logic             ram_internal,   // Internal RAM selected
	output logic             standby_hit     // Retained region hit
);

	// =====================================================
	// Helpers
	function automatic irsc_pkg::irsc_src_t pick_src(
		input logic nmi, input logic trap, input logic ext,
		input logic cap, input logic cmp, input logic ovf);
		if (nmi)       pick_src = irsc_pkg::IRSC_SRC_NMI;
		else if (trap) pick_src = irsc_pkg::IRSC_SRC_TRAP;
		else if (ext)  pick_src = irsc_pkg::IRSC_SRC_EXT;
		else if (cap)  pick_src = irsc_pkg::IRSC_SRC_CAPTURE;
		else if (cmp)  pick_src = irsc_pkg::IRSC_SRC_COMPARE;
		else if (ovf)  pick_src = irsc_pkg::IRSC_SRC_OVERFLOW;
		else           pick_src = irsc_pkg::IRSC_SRC_SERIAL;
	endfunction

	function automatic logic [15:0] vec_of(
		input irsc_pkg::irsc_src_t s);
		unique case (s)
			irsc_pkg::IRSC_SRC_NMI:      vec_of = `IRSC_VEC_NMI;
			irsc_pkg::IRSC_SRC_TRAP:     vec_of = `IRSC_VEC_TRAP;
			irsc_pkg::IRSC_SRC_EXT:      vec_of = `IRSC_VEC_EXT;
			irsc_pkg::IRSC_SRC_CAPTURE:  vec_of = `IRSC_VEC_CAPTURE;
			irsc_pkg::IRSC_SRC_COMPARE:  vec_of = `IRSC_VEC_COMPARE;
			irsc_pkg::IRSC_SRC_OVERFLOW: vec_of = `IRSC_VEC_OVERFLOW;
			irsc_pkg::IRSC_SRC_SERIAL:   vec_of = `IRSC_VEC_SERIAL;
			irsc_pkg::IRSC_SRC_RESET:    vec_of = `IRSC_VEC_RESET;
		endcase
	endfunction

	// =====================================================
	// Pin synchronisers
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [2:0] mode_s1_reg;
	logic [2:0] mode_s2_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg   <= 5'h1f;
			sync2_reg   <= 5'h1f;
			mode_s1_reg <= 3'h0;
			mode_s2_reg <= 3'h0;
		end else if (clk_en) begin
			sync1_reg   <= {nmi_n, ext_line_n, chip_clear_n,
				standby_power_ok, 1'b1};
			sync2_reg   <= sync1_reg;
			mode_s1_reg <= mode_pins;
			mode_s2_reg <= mode_s1_reg;
		end
	end

	wire nmi_lvl  = sync2_reg[4];
	wire ext_lvl  = sync2_reg[3];
	wire clr_lvl  = sync2_reg[2];
	wire stby_lvl = sync2_reg[1];

	// =====================================================
	// Bus clock, divide by four
	logic [1:0] div_reg;
	logic       e_reg;
	wire        e_tick = clk_en && (div_reg == `IRSC_DIV_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_reg <= 2'h0;
			e_reg   <= 1'b0;
		end else if (clk_en) begin
			div_reg <= div_reg + 2'h1; // [R21]
			e_reg   <= (div_reg == 2'h1) || (div_reg == 2'h2);
		end
	end

	// =====================================================
	// Request sources
	logic nmi_samp_reg;
	logic nmi_pend_reg;
	logic clr_prev_reg;
	logic mask_reg;
	irsc_pkg::irsc_state_t state_reg;

	wire in_reset  = !clr_lvl;
	wire clr_rise  = clk_en && clr_lvl && !clr_prev_reg;
	// Sampling once per E-cycle makes a one E-cycle pulse sure to be seen
	wire nmi_fall  = e_tick && nmi_samp_reg && !nmi_lvl; // [R10]
	wire ext_req   = !ext_lvl || port3_input_strobe; // [R3] [R22]
	wire cap_req   = capture_flag && timer_irq_en[0];
	wire cmp_req   = compare_flag && timer_irq_en[1];
	wire ovf_req   = overflow_flag && timer_irq_en[2];
	wire ser_req   = serial_irq_en && (rx_full_flag ||
		overrun_framing_flag || tx_empty_flag);
	wire int_req   = cap_req || cmp_req || ovf_req || ser_req; // [R3]
	wire mskb_req  = !mask_reg && (ext_req || int_req); // [R2]
	wire take      = clk_en && (state_reg == irsc_pkg::IRSC_IDLE) &&
		!in_reset && instr_done &&
		(nmi_pend_reg || soft_trap || mskb_req); // [R1] [R11]
	wire [2:0] take_src = pick_src(nmi_pend_reg, soft_trap,
		ext_req && !mask_reg, cap_req, cmp_req, ovf_req); // [R4] [R5]
	wire push_last = stack_ack && (stack_item == `IRSC_STACK_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_samp_reg <= 1'b1;
			nmi_pend_reg <= 1'b0;
			clr_prev_reg <= 1'b1;
		end else if (clk_en) begin
			clr_prev_reg <= clr_lvl;
			if (e_tick)
				nmi_samp_reg <= nmi_lvl;
			// A new edge beats the clear of the one being taken
			nmi_pend_reg <= nmi_fall || (nmi_pend_reg && !in_reset &&
				!(take && take_src == irsc_pkg::IRSC_SRC_NMI));
		end
	end

	// =====================================================
	// Sequencer
	irsc_pkg::irsc_state_t state_next;
	logic                  stack_req_reg;
	logic [2:0]            stack_item_reg;
	logic                  vec_req_reg;
	logic [15:0]           vec_addr_reg;
	logic [2:0]            src_reg;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			irsc_pkg::IRSC_IDLE:
				if (take)
					state_next = irsc_pkg::IRSC_STACK;
			irsc_pkg::IRSC_STACK:
				if (push_last)
					state_next = irsc_pkg::IRSC_VECTOR;
			irsc_pkg::IRSC_VECTOR:
				if (vec_ack)
					state_next = irsc_pkg::IRSC_IDLE;
			irsc_pkg::IRSC_RESET:
				if (clr_lvl)
					state_next = irsc_pkg::IRSC_VECTOR;
		endcase
		if (in_reset)
			state_next = irsc_pkg::IRSC_RESET;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= irsc_pkg::IRSC_RESET;
			stack_req_reg  <= 1'b0;
			stack_item_reg <= 3'h0;
			vec_req_reg    <= 1'b0;
			vec_addr_reg   <= `IRSC_VEC_RESET;
			src_reg        <= 3'h7;
		end else if (clk_en) begin
			state_reg <= state_next;
			if (in_reset) begin
				stack_req_reg <= 1'b0;
				vec_req_reg   <= 1'b0;
				vec_addr_reg  <= `IRSC_VEC_RESET; // [R8]
			end else if (state_reg == irsc_pkg::IRSC_RESET) begin
				// Reset stacks nothing and goes straight to its vector
				vec_req_reg  <= 1'b1;
				vec_addr_reg <= `IRSC_VEC_RESET; // [R8]
			end else if (take) begin
				src_reg        <= take_src;
				stack_req_reg  <= 1'b1; // [R6]
				stack_item_reg <= irsc_pkg::IRSC_PUSH_PC;
			end else if (state_reg == irsc_pkg::IRSC_STACK &&
				stack_ack) begin
				stack_item_reg <= stack_item_reg + 3'h1; // [R6]
				if (push_last) begin
					stack_req_reg <= 1'b0;
					vec_req_reg   <= 1'b1; // [R7]
					vec_addr_reg  <= vec_of(
						irsc_pkg::irsc_src_t'(src_reg)); // [R8] [R9]
				end
			end else if (state_reg == irsc_pkg::IRSC_VECTOR &&
				vec_ack) begin
				vec_req_reg <= 1'b0; // [R7]
			end
		end
	end

	// =====================================================
	// Mask flag, mode latch, reset outputs
	logic [2:0] mode_reg;
	logic       addr_force_reg;
	logic       vec_ext_reg;
	wire mask_next = in_reset || mask_set ||
		(state_reg == irsc_pkg::IRSC_STACK && push_last) ||
		(mask_reg && !mask_clear); // [R7] [R14]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg       <= 1'b1;
			mode_reg       <= 3'h0;
			addr_force_reg <= 1'b1;
			vec_ext_reg    <= 1'b0;
		end else if (clk_en) begin
			mask_reg       <= mask_next;
			addr_force_reg <= in_reset; // [R14]
			vec_ext_reg    <= EXT_VEC_MODES[mode_reg]; // [R15]
			if (clr_rise)
				mode_reg <= mode_s2_reg; // [R13] [R15]
		end
	end

	// =====================================================
	// RAM control register and APB slave
	logic       stby_reg;
	logic       ram_en_reg;
	logic       ram_int_reg;
	logic       stby_hit_reg;
	logic [7:0] rdata_reg;
	logic       ready_reg;
	logic       err_reg;

	wire hit_ram  = (paddr == `IRSC_RAMCTL_OFS);
	wire setup    = psel && !penable;
	wire wr_go    = psel && penable && ready_reg && pwrite && hit_ram;
	wire [7:0] rd_val = {stby_reg, ram_en_reg, 6'h00}; // [R23]
	wire in_ram   = (cpu_addr >= `IRSC_RAM_FIRST) &&
		(cpu_addr <= `IRSC_RAM_LAST);
	wire in_stby  = (cpu_addr >= `IRSC_RAM_FIRST) &&
		(cpu_addr <= `IRSC_STBY_LAST);
	// Supply loss beats a software set in the same cycle
	wire stby_next = stby_lvl &&
		(stby_reg || (wr_go && pwdata[`IRSC_STBY_BIT])); // [R18]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stby_reg     <= 1'b0;
			ram_en_reg   <= 1'b0;
			ram_int_reg  <= 1'b0;
			stby_hit_reg <= 1'b0;
			rdata_reg    <= 8'h00;
			ready_reg    <= 1'b0;
			err_reg      <= 1'b0;
		end else if (clk_en) begin
			// Chip clear leaves the standby bit alone [R18] [R19]
			stby_reg <= stby_next;
			if (clr_rise)
				ram_en_reg <= stby_lvl; // [R16]
			else if (wr_go)
				ram_en_reg <= pwdata[`IRSC_RAMEN_BIT]; // [R20]
			ram_int_reg  <= ram_en_reg && in_ram &&
				(mode_reg != `IRSC_NO_RAM_MODE); // [R17]
			stby_hit_reg <= ram_en_reg && in_stby; // [R19]
			ready_reg    <= setup;
			// Error flop rises with ready so the port needs no gate
			err_reg      <= setup && !hit_ram;
			if (setup)
				rdata_reg <= hit_ram ? rd_val : 8'h00;
		end
	end

	// =====================================================
	// Outputs
	assign prdata          = {24'h000000, rdata_reg};
	assign pready          = ready_reg;
	assign pslverr         = err_reg;
	assign bus_clk_e       = e_reg;
	assign stack_req       = stack_req_reg;
	assign stack_item      = stack_item_reg;
	assign vec_req         = vec_req_reg;
	assign vec_addr        = vec_addr_reg;
	assign vec_external    = vec_ext_reg;
	assign mask_flag       = mask_reg;
	assign mode_sel        = mode_reg;
	assign addr_high_force = addr_force_reg;
	assign ram_internal    = ram_int_reg;
	assign standby_hit     = stby_hit_reg;

	// =====================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	nmi_taken_a: assert property (clk_en && !in_reset && nmi_pend_reg &&
		instr_done && state_reg == irsc_pkg::IRSC_IDLE |=>
		state_reg == irsc_pkg::IRSC_STACK) // [R1]
		else $error("nmi not taken");
	mask_holds_a: assert property (clk_en && mask_reg && !nmi_pend_reg &&
		!soft_trap && state_reg == irsc_pkg::IRSC_IDLE |=>
		state_reg != irsc_pkg::IRSC_STACK) // [R2]
		else $error("masked request taken");
	ext_first_a: assert property (take && !nmi_pend_reg && !soft_trap &&
		ext_req && int_req |=> src_reg == irsc_pkg::IRSC_SRC_EXT) // [R4]
		else $error("external line not first");
	capture_first_a: assert property (take && !nmi_pend_reg &&
		!soft_trap && !ext_req && cap_req && cmp_req |=>
		src_reg == irsc_pkg::IRSC_SRC_CAPTURE) // [R5]
		else $error("internal priority wrong");
	stack_five_a: assert property ($rose(vec_req_reg) &&
		state_reg == irsc_pkg::IRSC_VECTOR &&
		$past(state_reg) == irsc_pkg::IRSC_STACK |->
		$past(stack_item_reg) == 3'h4) // [R6]
		else $error("vector before five pushes");
	mask_on_vec_a: assert property (clk_en && push_last && !in_reset &&
		state_reg == irsc_pkg::IRSC_STACK |=>
		mask_reg && vec_req_reg && vec_addr_reg ==
		vec_of(irsc_pkg::irsc_src_t'(src_reg))) // [R7] [R9]
		else $error("mask or vector wrong");
	reset_vec_a: assert property (clr_rise |=> ##[0:2]
		vec_req_reg && vec_addr_reg == 16'hfffe) // [R8]
		else $error("reset vector wrong");
	mode_latch_a: assert property (clr_rise |=>
		mode_reg == $past(mode_s2_reg)) // [R13]
		else $error("mode not latched");
	reset_mask_a: assert property (clk_en && in_reset |=>
		mask_reg && addr_force_reg) // [R14]
		else $error("reset outputs wrong");
	ram_off_a: assert property (clk_en && !ram_en_reg |=>
		!ram_int_reg) // [R17]
		else $error("ram selected while off");
	stby_lost_a: assert property (clk_en && !stby_lvl |=>
		!stby_reg) // [R18]
		else $error("standby bit kept");
	e_div_a: assert property (e_tick |=> !e_reg) // [R21]
		else $error("bus clock phase wrong");

endmodule : irsc_ctrl

// ===== tb/irsc_cpu_model.sv
// CPU-side partner: answers stack pushes and vector fetches
module irsc_cpu_model (
	input  wire logic        pclk,       // Clock
	input  wire logic        presetn,    // Async reset, active low
	input  wire logic        slow,       // Stretch each answer
	input  wire logic        stack_req,  // Push request
	input  wire logic [2:0]  stack_item, // Item to push
	input  wire logic        vec_req,    // Vector request
	input  wire logic [15:0] vec_addr,   // Vector pair high byte
	output logic             stack_ack,  // One push done
	output logic             vec_ack,    // Vector loaded
	output logic      [14:0] push_log,   // Items of last entry
	output logic      [2:0]  push_n,     // Pushes of last entry
	output logic      [15:0] vec_seen    // Vector of last entry
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0]  wait_cnt;
	logic [14:0] log_run;
	logic [2:0]  n_run;
	// ==========================================
	// Answers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stack_ack <= 1'b0;
			vec_ack <= 1'b0;
			wait_cnt <= 2'h0;
			log_run <= 15'h0;
			n_run <= 3'h0;
			push_log <= 15'h0;
			push_n <= 3'h0;
			vec_seen <= 16'h0;
		end else begin
			// Gap after each pulse keeps acks inside their request
			stack_ack <= stack_req & !stack_ack & (wait_cnt == 2'h0);
			vec_ack <= vec_req & !vec_ack & (wait_cnt == 2'h0);
			if (!(stack_req | vec_req) || stack_ack || vec_ack)
				wait_cnt <= slow ? 2'h3 : 2'h0;
			else if (wait_cnt != 2'h0)
				wait_cnt <= wait_cnt - 2'h1;
			if (stack_ack && stack_req) begin
				log_run <= {log_run[11:0], stack_item};
				n_run <= n_run + 3'h1;
			end
			if (vec_ack && vec_req) begin
				vec_seen <= vec_addr;
				push_log <= log_run;
				push_n <= n_run;
				log_run <= 15'h0;
				n_run <= 3'h0;
			end
		end
	end
endmodule // irsc_cpu_model

// ===== tb/test_interrupt_reset_standby_ctrl.sv
// Testbench for the interrupt, reset and standby RAM control block
module test_interrupt_reset_standby_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        nmi_n, ext_line_n, port3_input_strobe, chip_clear_n;
	logic [2:0]  mode_pins, timer_irq_en, stack_item, mode_sel, push_n;
	logic        standby_power_ok, serial_irq_en, instr_done, soft_trap;
	logic        mask_set, mask_clear, stack_ack, vec_ack, slow, er, clk_en;
	logic [5:0]  fl;
	logic [15:0] cpu_addr, vec_addr, vec_seen;
	logic        bus_clk_e, stack_req, vec_req, vec_external, mask_flag;
	logic        addr_high_force, ram_internal, standby_hit, pe;
	logic [14:0] push_log;
	logic [15:0] vt [6] = '{16'hfff6, 16'hfff4, 16'hfff2,
		16'hfff0, 16'hfff0, 16'hfff0};
	int          errors = 0;
	int          cmp_count = 0;
	int          h, r;

	always #2.5 pclk = ~pclk;

	// Mode 3 takes its vectors from outside in this bench
	irsc_ctrl #(.EXT_VEC_MODES(8'h08)) dut (.pclk, .presetn, .clk_en,
		.psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .nmi_n,
		.ext_line_n, .port3_input_strobe, .chip_clear_n, .mode_pins,
		.standby_power_ok, .capture_flag(fl[0]), .compare_flag(fl[1]),
		.overflow_flag(fl[2]), .timer_irq_en, .rx_full_flag(fl[3]),
		.overrun_framing_flag(fl[4]), .tx_empty_flag(fl[5]),
		.serial_irq_en, .instr_done, .soft_trap, .mask_set, .mask_clear,
		.stack_ack, .vec_ack, .cpu_addr, .bus_clk_e, .stack_req,
		.stack_item, .vec_req, .vec_addr, .vec_external, .mask_flag,
		.mode_sel, .addr_high_force, .ram_internal, .standby_hit);

	irsc_cpu_model cpu (.pclk, .presetn, .slow, .stack_req, .stack_item,
		.vec_req, .vec_addr, .stack_ack, .vec_ack, .push_log, .push_n,
		.vec_seen);

	// ==========================================
	// Shared tasks
	task finish_test();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task give_up(input string nm);
		errors++;
		$display("[FAIL] %s expected done seen hang", nm);
		finish_test();
	endtask

	// Master holds the request until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			give_up("apb");
	endtask

	task rdchk(input logic [31:0] e);
		apb(1'b0, 8'h14, 32'h0);
		chk("ram_ctl", e, rd);
		chk("slverr", 32'h0, {31'h0, er});
	endtask

	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task wreq(input logic v);
		int n;
		n = 0;
		while (vec_req !== v && n < 400) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 400)
			give_up("vec_req");
	endtask

	task run_irq(input logic [15:0] v, input logic [2:0] pn);
		wreq(1'b1);
		wreq(1'b0);
		chk("vector", {16'h0, v}, {16'h0, vec_seen});
		chk("pushes", {29'h0, pn}, {29'h0, push_n});
		if (pn == 3'h5)
			chk("push_order", 32'h029c, {17'h0, push_log});
		chk("mask", 32'h1, {31'h0, mask_flag});
	endtask

	task quiet();
		logic bad;
		bad = 1'b0;
		repeat (30) begin
			@(posedge pclk);
			if (stack_req !== 1'b0)
				bad = 1'b1;
		end
		chk("no_take", 32'h0, {31'h0, bad});
	endtask

	task pulse_clr();
		@(posedge pclk);
		mask_clear <= 1'b1;
		@(posedge pclk);
		mask_clear <= 1'b0;
	endtask

	// Chip clear held 16 clocks, past the three bus-clock minimum
	task cc(input logic [2:0] m, input logic sb);
		@(posedge pclk);
		mode_pins <= m;
		standby_power_ok <= sb;
		chip_clear_n <= 1'b0;
		cyc(16);
		chk("addr_force", 32'h1, {31'h0, addr_high_force});
		chip_clear_n <= 1'b1;
		run_irq(16'hfffe, 3'h0);
		chk("mode", {29'h0, m}, {29'h0, mode_sel});
		chk("addr_force", 32'h0, {31'h0, addr_high_force});
		chk("vec_ext", {31'h0, m == 3'h3}, {31'h0, vec_external});
	endtask

	// ==========================================
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{clk_en, nmi_n, ext_line_n, chip_clear_n, standby_power_ok} = 5'h1f;
		{port3_input_strobe, soft_trap, mask_set, mask_clear} = 4'h0;
		{fl, timer_irq_en, serial_irq_en, slow, cpu_addr} = '0;
		mode_pins = 3'h5;
		instr_done = 1'b1;
		cyc(8);
		presetn <= 1'b1;
		run_irq(16'hfffe, 3'h0);
		h = 0;
		r = 0;
		pe = bus_clk_e;
		repeat (16) begin
			@(posedge pclk);
			h += (bus_clk_e === 1'b1);
			r += (bus_clk_e === 1'b1 && pe === 1'b0);
			pe = bus_clk_e;
		end
		chk("e_high", 32'd8, h);
		chk("e_rise", 32'd4, r);
		// Clock enable low must freeze the bus clock
		clk_en <= 1'b0;
		@(posedge pclk);
		pe = bus_clk_e;
		h = 0;
		repeat (8) begin
			@(posedge pclk);
			h += (bus_clk_e !== pe);
		end
		clk_en <= 1'b1;
		chk("e_frozen", 32'd0, h);
		$display("test reset_clock done");
		cc(3'h5, 1'b1);
		rdchk(32'h40);
		apb(1'b1, 8'h14, 32'hff);
		rdchk(32'hc0);
		apb(1'b0, 8'h18, 32'h0);
		chk("slverr", 32'h1, {31'h0, er});
		cpu_addr <= 16'h0090;
		cyc(3);
		chk("ram_int", 32'h1, {31'h0, ram_internal});
		chk("stby_hit", 32'h1, {31'h0, standby_hit});
		cpu_addr <= 16'h00c0;
		cyc(3);
		chk("stby_hit", 32'h0, {31'h0, standby_hit});
		apb(1'b1, 8'h14, 32'h80);
		cyc(3);
		chk("ram_int", 32'h0, {31'h0, ram_internal});
		cc(3'h3, 1'b1);
		rdchk(32'hc0);
		cpu_addr <= 16'h0090;
		cyc(3);
		chk("ram_int", 32'h0, {31'h0, ram_internal});
		standby_power_ok <= 1'b0;
		cyc(8);
		rdchk(32'h40);
		$display("test standby_ram done");
		cc(3'h5, 1'b1);
		ext_line_n <= 1'b0;
		fl <= 6'h3f;
		quiet();
		pulse_clr();
		run_irq(16'hfff8, 3'h5);
		pulse_clr();
		run_irq(16'hfff8, 3'h5);
		ext_line_n <= 1'b1;
		cyc(4);
		pulse_clr();
		quiet();
		mask_set <= 1'b1;
		cyc(1);
		mask_set <= 1'b0;
		cyc(2);
		chk("mask_set", 32'h1, {31'h0, mask_flag});
		timer_irq_en <= 3'h7;
		serial_irq_en <= 1'b1;
		ext_line_n <= 1'b0;
		slow <= 1'b1;
		cyc(4);
		pulse_clr();
		run_irq(16'hfff8, 3'h5);
		ext_line_n <= 1'b1;
		cyc(4);
		for (int k = 0; k < 6; k++) begin
			pulse_clr();
			run_irq(vt[k], 3'h5);
			fl[k] <= 1'b0;
		end
		port3_input_strobe <= 1'b1;
		pulse_clr();
		run_irq(16'hfff8, 3'h5);
		port3_input_strobe <= 1'b0;
		$display("test maskable done");
		instr_done <= 1'b0;
		nmi_n <= 1'b0;
		cyc(8);
		nmi_n <= 1'b1;
		quiet();
		instr_done <= 1'b1;
		run_irq(16'hfffc, 3'h5);
		soft_trap <= 1'b1;
		cyc(1);
		soft_trap <= 1'b0;
		run_irq(16'hfffa, 3'h5);
		$display("test nonmaskable done");
		// Power-on reset in mid-run clears both control bits
		presetn <= 1'b0;
		cyc(2);
		chk("rst_force", 32'h1, {31'h0, addr_high_force});
		chk("rst_vec", 32'h0, {31'h0, vec_req});
		presetn <= 1'b1;
		run_irq(16'hfffe, 3'h0);
		rdchk(32'h0);
		$display("test power_reset done");
		finish_test();
	end
endmodule // test_interrupt_reset_standby_ctrl
